// File: spme_entry.sv
/*
 Serial programming mode entry: high and low voltage entry, key check,
 data pin direction, clear-reset forcing and low-voltage bit protection.
 Assumes the core device supplies the configuration bits and the serial
 command engine drives outgoing data through progDataOut/progDataDrive.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spme_defs.svh"
// What this block does
// RULE1: Program, ID and configuration writes are allowed only in program mode via the serial pins.
// RULE2: The data pin is two-way and the clock pin is only an input clocked by the programmer.
// RULE3: For high-voltage entry the programmer holds clock and data low before raising clear.
// RULE4: Low-voltage entry is possible only while the low-voltage enable bit is one.
// RULE5: For low-voltage entry the programmer drives clear low, then clocks in a 32-bit key.
// RULE6: After a good key the device stays in program mode only while clear stays low.
// RULE7: When the low-voltage enable bit is one the clear reset function is forced on.
// RULE8: Clearing the low-voltage enable bit is accepted only in a high-voltage session.
// RULE9: A wrong key leaves the device out of program mode with normal reset behaviour.
// RULE10: Key bits are taken on the programming clock rising edge; clear going high restarts.
module spme_entry #(
    parameter logic [31:0] KEY_VALUE = `SPME_KEY_DEFAULT
) (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  progClockPinIn,
    input  wire logic  progDataPinIn,
    input  wire logic  masterClearPinIn,
    input  wire logic  highProgLevelIn,
    input  wire logic  lowVoltageProgEnable,
    input  wire logic  clearResetCfgEnable,
    input  wire logic  progDataOut,
    input  wire logic  progDataDrive,
    input  wire logic  memWriteReq,
    input  wire logic  lvBitClearReq,
    output var  logic  progDataPinOut,
    output var  logic  progDataPinOe,
    output var  logic  progModeActive,
    output var  logic  highVoltageSession,
    output var  logic  clearResetEnabled,
    output var  logic  memWriteGrant,
    output var  logic  lvBitClearGrant,
    output var  logic  deviceResetHold
);
    // ========================================
    // Pin front end
    spme_pin_if pins ();

    spme_pin_sync u_sync (
        .clk              (clk),
        .rst              (rst),
        .progClockPinIn   (progClockPinIn),
        .progDataPinIn    (progDataPinIn),
        .masterClearPinIn (masterClearPinIn),
        .highProgLevelIn  (highProgLevelIn),
        .pins             (pins.front)
    );

    localparam int KEY_W = `SPME_KEY_BITS;
    localparam int HV_CYC = `SPME_HV_SETTLE_CYC;

    spme_pkg::spme_mode_e mode_q;
    logic [KEY_W-1:0]     key_q;
    logic [5:0]           keyCount_q;
    logic [7:0]           hvCount_q;
    logic                 keyDone;
    logic                 inProg;

    assign keyDone = (keyCount_q == 6'(KEY_W));
    assign inProg  = (mode_q == spme_pkg::SPME_PROG_LV) || (mode_q == spme_pkg::SPME_PROG_HV);

    // ========================================
    // Key shift register, MSB first
    always_ff @(posedge clk) begin
        if (rst || pins.clearHigh || mode_q != spme_pkg::SPME_LV_KEY) begin
            key_q      <= '0; // RULE10
            keyCount_q <= 6'h00;
        end else if (pins.clkRise && !keyDone) begin
            key_q      <= {key_q[KEY_W-2:0], pins.dataLevel}; // RULE5 RULE10
            keyCount_q <= keyCount_q + 6'h01;
        end
    end

    // ========================================
    // High-voltage settle counter
    always_ff @(posedge clk) begin
        if (rst || mode_q != spme_pkg::SPME_HV_WAIT) begin
            hvCount_q <= 8'h00;
        end else if (hvCount_q != 8'(HV_CYC)) begin
            hvCount_q <= hvCount_q + 8'h01;
        end
    end

    // ========================================
    // Mode state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= spme_pkg::SPME_NORMAL;
        end else begin
            case (mode_q)
                spme_pkg::SPME_NORMAL: begin
                    // Clock and data low in any cycle while high level is present
                    if (pins.highLevel && !pins.clockLevel && !pins.dataLevel) begin
                        mode_q <= spme_pkg::SPME_HV_WAIT; // RULE3
                    end else if (pins.clearLow && lowVoltageProgEnable) begin
                        mode_q <= spme_pkg::SPME_LV_KEY; // RULE4
                    end
                end
                spme_pkg::SPME_HV_WAIT: begin
                    if (!pins.highLevel) begin
                        mode_q <= spme_pkg::SPME_NORMAL;
                    end else if (hvCount_q == 8'(HV_CYC)) begin
                        mode_q <= spme_pkg::SPME_PROG_HV;
                    end
                end
                spme_pkg::SPME_LV_KEY: begin
                    if (pins.clearHigh || !lowVoltageProgEnable) begin
                        mode_q <= spme_pkg::SPME_NORMAL; // RULE4 RULE10
                    end else if (keyDone) begin
                        mode_q <= (key_q == KEY_VALUE) ? spme_pkg::SPME_PROG_LV
                                                       : spme_pkg::SPME_LV_REJECT; // RULE9
                    end
                end
                spme_pkg::SPME_LV_REJECT: begin
                    // Bad key: wait for clear release before retrying
                    if (pins.clearHigh) begin
                        mode_q <= spme_pkg::SPME_NORMAL; // RULE9
                    end
                end
                spme_pkg::SPME_PROG_LV: begin
                    if (pins.clearHigh) begin
                        mode_q <= spme_pkg::SPME_NORMAL; // RULE6
                    end
                end
                spme_pkg::SPME_PROG_HV: begin
                    if (!pins.highLevel) begin
                        mode_q <= spme_pkg::SPME_NORMAL;
                    end
                end
                default: mode_q <= spme_pkg::SPME_NORMAL;
            endcase
        end
    end

    // ========================================
    // Registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            progModeActive     <= 1'b0;
            highVoltageSession <= 1'b0;
            memWriteGrant      <= 1'b0;
            lvBitClearGrant    <= 1'b0;
        end else begin
            progModeActive     <= inProg;
            highVoltageSession <= (mode_q == spme_pkg::SPME_PROG_HV);
            memWriteGrant      <= inProg && memWriteReq; // RULE1
            lvBitClearGrant    <= (mode_q == spme_pkg::SPME_PROG_HV) && lvBitClearReq; // RULE8
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            clearResetEnabled <= 1'b1;
            deviceResetHold   <= 1'b1;
        end else begin
            clearResetEnabled <= clearResetCfgEnable || lowVoltageProgEnable; // RULE7
            // Core held in reset while programming, or while clear is low with the clear reset function on
            deviceResetHold   <= inProg ||
                                 (pins.clearLow && (clearResetCfgEnable || lowVoltageProgEnable)); // RULE7 RULE9
        end
    end

    // Data pin driven only in program mode, at the engine's request
    always_ff @(posedge clk) begin
        if (rst) begin
            progDataPinOut <= 1'b0;
            progDataPinOe  <= 1'b0;
        end else begin
            progDataPinOut <= progDataOut;
            progDataPinOe  <= inProg && progDataDrive; // RULE2
        end
    end

    // ========================================
    // Checks
    a_lv_gate_off: assert property (@(posedge clk) disable iff (rst)
        (mode_q == spme_pkg::SPME_NORMAL && !lowVoltageProgEnable && !pins.highLevel)
        |=> mode_q != spme_pkg::SPME_LV_KEY) // RULE4
        else $error("low-voltage entry taken while disabled");

    a_clear_forced: assert property (@(posedge clk) disable iff (rst)
        lowVoltageProgEnable |=> clearResetEnabled) // RULE7
        else $error("clear reset not forced on");

    a_lv_clear_hv: assert property (@(posedge clk) disable iff (rst)
        lvBitClearGrant |-> $past(mode_q == spme_pkg::SPME_PROG_HV)) // RULE8
        else $error("low-voltage bit clear outside high-voltage session");

    a_bad_key: assert property (@(posedge clk) disable iff (rst)
        (mode_q == spme_pkg::SPME_LV_KEY && keyDone && key_q != KEY_VALUE && pins.clearLow
         && lowVoltageProgEnable) |=> ##1 !progModeActive) // RULE9
        else $error("wrong key entered program mode");

    a_lv_exit: assert property (@(posedge clk) disable iff (rst)
        (mode_q == spme_pkg::SPME_PROG_LV && pins.clearHigh) |=> ##1 !progModeActive) // RULE6
        else $error("program mode held after clear release");

    a_write_gate: assert property (@(posedge clk) disable iff (rst)
        memWriteGrant |-> $past(inProg) && $past(memWriteReq)) // RULE1
        else $error("write granted outside program mode");

    a_data_drive: assert property (@(posedge clk) disable iff (rst)
        progDataPinOe |-> $past(inProg)) // RULE2
        else $error("data pin driven outside program mode");

    a_key_restart: assert property (@(posedge clk) disable iff (rst)
        (mode_q == spme_pkg::SPME_LV_KEY && pins.clearHigh) |=> keyCount_q == 6'h00) // RULE10
        else $error("key count kept after clear release");

    a_key_shift: assert property (@(posedge clk) disable iff (rst)
        (mode_q == spme_pkg::SPME_LV_KEY && pins.clkRise && !keyDone && pins.clearLow)
        |=> keyCount_q == $past(keyCount_q) + 6'h01) // RULE5
        else $error("key bit not taken on clock edge");
endmodule
`default_nettype wire

// File: spme_defs.svh
/*
 Timing counts, key layout and reset values for the serial programming
 mode entry block. Assumes inclusion by bare name from design files.
*/
`ifndef SPME_DEFS_SVH
`define SPME_DEFS_SVH

`define SPME_KEY_BITS       32
`define SPME_KEY_DEFAULT    32'h5A5A_C3E1
`define SPME_SYNC_STAGES    3
`define SPME_PIN_IDLE       4'h4
`define SPME_HV_SETTLE_NS   100
`define SPME_CLK_PERIOD_NS  5
`define SPME_HV_SETTLE_CYC  ((`SPME_HV_SETTLE_NS + `SPME_CLK_PERIOD_NS - 1) / `SPME_CLK_PERIOD_NS)

`endif

// File: spme_pkg.sv
/*
 Types shared by the serial programming mode entry block.
 Assumes spme_defs.svh is available for constants.
*/
package spme_pkg;
    typedef enum {
        SPME_NORMAL,
        SPME_LV_KEY,
        SPME_LV_REJECT,
        SPME_HV_WAIT,
        SPME_PROG_LV,
        SPME_PROG_HV
    } spme_mode_e;
endpackage

// File: spme_pin_if.sv
/*
 Synchronised pin view passed from the pin front end to the entry core.
 Assumes a single clk domain on both sides.
*/
`timescale 1ns/1ps
`default_nettype none
interface spme_pin_if;
    logic clkRise;
    logic dataLevel;
    logic clearLow;
    logic clearHigh;
    logic highLevel;
    logic clockLevel;
    modport front (output clkRise, output dataLevel, output clearLow,
                   output clearHigh, output highLevel, output clockLevel);
    modport core  (input clkRise, input dataLevel, input clearLow,
                   input clearHigh, input highLevel, input clockLevel);
endinterface
`default_nettype wire

// File: spme_pin_sync.sv
/*
 Three-stage pin synchronisers and programming clock edge finder.
 Assumes pins are asynchronous to clk; a change counts when stages 2 and 3 agree.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spme_defs.svh"
module spme_pin_sync (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  progClockPinIn,
    input  wire logic  progDataPinIn,
    input  wire logic  masterClearPinIn,
    input  wire logic  highProgLevelIn,
    spme_pin_if.front  pins
);
    // ========================================
    // Synchronisers, one per pin
    logic [3:0] rawPins;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] stable_q;
    logic       clkPrev_q;
    // Idle levels: a zero reset on clear would fake a clear-low after reset
    localparam logic [3:0] PIN_IDLE = `SPME_PIN_IDLE;

    assign rawPins = {highProgLevelIn, masterClearPinIn, progDataPinIn, progClockPinIn};

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_q[i] <= PIN_IDLE[i];
                    s2_q[i] <= PIN_IDLE[i];
                    s3_q[i] <= PIN_IDLE[i];
                    stable_q[i] <= PIN_IDLE[i];
                end else begin
                    s1_q[i] <= rawPins[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    // Filter: accept only when two late stages agree
                    if (s2_q[i] == s3_q[i]) begin
                        stable_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate

    // ========================================
    // Programming clock edge: clock pin is input only
    always_ff @(posedge clk) begin
        if (rst) begin
            clkPrev_q <= 1'b0;
        end else begin
            clkPrev_q <= stable_q[0];
        end
    end

    assign pins.clkRise    = stable_q[0] & ~clkPrev_q; // RULE2 RULE10
    assign pins.clockLevel = stable_q[0];
    assign pins.dataLevel  = stable_q[1];
    assign pins.clearLow   = ~stable_q[2];
    assign pins.clearHigh  = stable_q[2];
    assign pins.highLevel  = stable_q[3];
endmodule
`default_nettype wire

// File: spme_programmer.sv
/*
 Programmer model for the serial programming mode entry block.
 Assumes clk is the device clock; the link clock runs at 80 ns per period
 only inside a key frame and rests low outside it.
*/
`timescale 1ns/1ps
`default_nettype none
module spme_programmer (
    input  wire logic  clk,
    input  wire logic  devDataOut,
    input  wire logic  devDataOe,
    output var  logic  progClockPin,
    output var  logic  progDataPin,
    output var  logic  masterClearPin,
    output var  logic  highProgLevel
);
    logic dataDrive_q;
    logic dataVal_q;

    initial begin
        progClockPin   = 1'b0;
        masterClearPin = 1'b1;
        highProgLevel  = 1'b0;
        dataDrive_q    = 1'b0;
        dataVal_q      = 1'b0;
    end

    // Released line shows the inverse of its last level, never a stale copy
    always_comb progDataPin = devDataOe ? devDataOut : (dataDrive_q ? dataVal_q : ~dataVal_q);

    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Clear held low for the whole frame and after it
    task automatic sendKey(input logic [31:0] key);
        @(posedge clk);
        masterClearPin <= 1'b0;
        dataDrive_q    <= 1'b1;
        waitClk(8);
        for (int i = 31; i >= 0; i--) begin
            dataVal_q <= key[i];
            waitClk(8);
            progClockPin <= 1'b1;
            waitClk(8);
            progClockPin <= 1'b0;
        end
        dataDrive_q <= 1'b0;
    endtask

    task automatic leaveLv();
        @(posedge clk);
        masterClearPin <= 1'b1;
    endtask

    task automatic enterHv();
        @(posedge clk);
        progClockPin <= 1'b0;
        dataDrive_q  <= 1'b1;
        dataVal_q    <= 1'b0;
        waitClk(8);
        highProgLevel <= 1'b1;
    endtask

    task automatic leaveHv();
        @(posedge clk);
        highProgLevel <= 1'b0;
        dataDrive_q   <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: serial_program_mode_entry_bench.sv
/*
 Self-checking bench for spme_entry with a programmer model.
 Assumes spme_defs.svh on the include path and spme_programmer compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spme_defs.svh"
module serial_program_mode_entry_bench;
    localparam logic [31:0] GOOD_KEY = `SPME_KEY_DEFAULT;
    logic clk, rst, lvEnable, cfgClearEn, engDataOut, engDataDrive, memWriteReq, lvBitClearReq;
    logic clockPin, dataPin, clearPin, highLvl, pinOut, pinOe, modeActive, hvSession;
    logic clearResetEn, memGrant, lvGrant, resetHold;
    logic [31:0] key;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    spme_entry #(.KEY_VALUE(GOOD_KEY)) uut (.clk(clk), .rst(rst), .progClockPinIn(clockPin),
        .progDataPinIn(dataPin), .masterClearPinIn(clearPin), .highProgLevelIn(highLvl),
        .lowVoltageProgEnable(lvEnable), .clearResetCfgEnable(cfgClearEn),
        .progDataOut(engDataOut), .progDataDrive(engDataDrive), .memWriteReq(memWriteReq),
        .lvBitClearReq(lvBitClearReq), .progDataPinOut(pinOut), .progDataPinOe(pinOe),
        .progModeActive(modeActive), .highVoltageSession(hvSession),
        .clearResetEnabled(clearResetEn), .memWriteGrant(memGrant),
        .lvBitClearGrant(lvGrant), .deviceResetHold(resetHold));
    spme_programmer p (.clk(clk), .devDataOut(pinOut), .devDataOe(pinOe),
        .progClockPin(clockPin), .progDataPin(dataPin), .masterClearPin(clearPin),
        .highProgLevel(highLvl));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic summarize();
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic expVal, input logic seen);
        samples_checked++;
        if (seen !== expVal) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", what, expVal, seen);
        end
    endtask

    function automatic logic expClearEn(input logic lv, input logic cfg);
        return lv | cfg;
    endfunction

    // Absence of entry is judged after the full bound has run out
    task automatic waitMode(input logic want, input int lim);
        int n;
        n = 0;
        while (modeActive !== want && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // Random write and drive requests, clear request held high; grants and drive only follow inside a session
    task automatic probe(input logic inMode, input logic hv);
        logic [2:0] r;
        repeat (6) begin
            r = 3'($urandom);
            @(posedge clk);
            memWriteReq   <= r[0];
            engDataDrive  <= r[1];
            engDataOut    <= r[2];
            lvBitClearReq <= 1'b1;
            @(posedge clk);
            #1;
            chk("memWriteGrant", inMode & r[0], memGrant);
            chk("progDataPinOe", inMode & r[1], pinOe);
            if (inMode & r[1])
                chk("dataPin", r[2], dataPin);
            chk("lvBitClearGrant", inMode & hv, lvGrant);
        end
        @(posedge clk);
        memWriteReq   <= 1'b0;
        engDataDrive  <= 1'b0;
        lvBitClearReq <= 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        {lvEnable, cfgClearEn, engDataOut, engDataDrive, memWriteReq, lvBitClearReq} = '0;
        void'($urandom(58));
        repeat (5) @(posedge clk);
        #1;
        chk("resetHold", 1'b1, resetHold);
        chk("clearResetEn", 1'b1, clearResetEn);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("modeActive", 1'b0, modeActive);
        chk("resetHold", 1'b0, resetHold);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            lvEnable   <= i[1];
            cfgClearEn <= i[0];
            repeat (4) @(posedge clk);
            #1;
            chk("clearResetEn", expClearEn(i[1], i[0]), clearResetEn);
        end
        // Disabled good key, enabled wrong key, enabled good key
        for (int c = 0; c < 3; c++) begin
            @(posedge clk);
            lvEnable <= (c != 0);
            key = GOOD_KEY;
            if (c == 1) begin
                key = $urandom;
                if (key === GOOD_KEY)
                    key = ~key;
            end
            p.sendKey(key);
            waitMode(1'b1, 40);
            chk("modeActive", c == 2, modeActive);
            chk("resetHold", expClearEn(c != 0, cfgClearEn), resetHold);
            if (c == 2)
                chk("hvSession", 1'b0, hvSession);
            probe(c == 2, 1'b0);
            p.leaveLv();
            waitMode(1'b0, 20);
            chk("modeActive", 1'b0, modeActive);
            // Let the release pass the synchronisers before the next frame
            repeat (8) @(posedge clk);
            #1;
            chk("resetHold", 1'b0, resetHold);
        end
        p.enterHv();
        waitMode(1'b1, 60);
        chk("modeActive", 1'b1, modeActive);
        chk("hvSession", 1'b1, hvSession);
        probe(1'b1, 1'b1);
        p.leaveHv();
        waitMode(1'b0, 20);
        chk("modeActive", 1'b0, modeActive);
        chk("hvSession", 1'b0, hvSession);
        summarize();
    end
endmodule
`default_nettype wire
